// ---- inc/lvm_pkg.sv ----
// constants, field positions and carrier types of the low-voltage monitor
package lvm_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL_ONE = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_CTRL_TWO = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 3'h3;

  // ==========================================================
  // first power-management register fields
  localparam int B_DET_FLAG = 7;
  localparam int B_DET_ACK = 6;
  localparam int B_DET_IRQ_EN = 5;
  localparam int B_DET_RST_EN = 4;
  localparam int B_DET_STOP_EN = 3;
  localparam int B_DET_EN = 2;
  localparam int B_REF_BUF_EN = 1;

  // ==========================================================
  // second power-management register fields
  localparam int B_WARN_FLAG = 7;
  localparam int B_WARN_ACK = 6;
  localparam int B_DET_TRIP = 5;
  localparam int B_WARN_TRIP = 4;
  localparam int B_DEEP_FLAG = 3;
  localparam int B_DEEP_ACK = 2;
  localparam int B_STOP_DEPTH = 0;

  // ==========================================================
  // event status / mask fields
  localparam int B_EV_DETECT = 0;
  localparam int B_EV_WARN = 1;
  localparam int B_EV_DEEP = 2;
  localparam int EV_W = 3;

  // ==========================================================
  // reset values
  localparam logic [DATA_W-1:0] RST_CTRL_ONE = 8'h00;
  localparam logic [DATA_W-1:0] RST_CTRL_TWO = 8'h00;
  localparam logic [EV_W-1:0] RST_EV = 3'h0;
  localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;

  // ==========================================================
  // carrier types
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } lvm_bus_req_t;

  typedef struct packed {
    logic detect_cmp;
    logic warn_cmp;
  } lvm_analog_t;

  typedef struct packed {
    logic stop_active;
    logic deep_stop_wake;
    logic reset_is_por;
  } lvm_sys_t;

endpackage

// ---- src/lvm_regs.sv ----
// low-voltage detect / warning status, control and stop-depth registers
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module lvm_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire lvm_pkg::lvm_bus_req_t bus_req,
  output logic [lvm_pkg::DATA_W-1:0] rdata,
  input wire lvm_pkg::lvm_analog_t analog_in,
  input wire lvm_pkg::lvm_sys_t sys_in,
  output logic irq,
  output logic reset_req,
  output logic reference_buffer_on,
  output logic detect_active,
  output logic detect_trip_select,
  output logic warning_trip_select,
  output logic stop_depth_select
);
  import lvm_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic det_s1;
    logic det_s2;
    logic warn_s1;
    logic warn_s2;
    logic undervolt_detect_flag;
    logic undervolt_irq_enable;
    logic undervolt_reset_enable;
    logic undervolt_stop_enable;
    logic undervolt_detect_enable;
    logic reference_buffer_enable;
    logic supply_warning_flag;
    logic detect_trip_select;
    logic warning_trip_select;
    logic deep_stop_recovery_flag;
    logic stop_depth_select;
    logic stop_depth_locked;
    logic [EV_W-1:0] ev_stat;
    logic [EV_W-1:0] ev_mask;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic reset_req;
    logic detect_active;
  } lvm_state_t;

  lvm_state_t st_q;
  lvm_state_t st_d;

  logic wr_one;
  logic wr_two;
  logic wr_mask;
  logic rd_stat;
  logic det_run;
  logic det_set;
  logic warn_set;
  logic deep_set;
  logic [EV_W-1:0] ev_new;
  logic [DATA_W-1:0] reg_one_view;
  logic [DATA_W-1:0] reg_two_view;

  // ==========================================================
  // decode
  assign wr_one = bus_req.wr && (bus_req.addr == OFF_CTRL_ONE);
  assign wr_two = bus_req.wr && (bus_req.addr == OFF_CTRL_TWO);
  assign wr_mask = bus_req.wr && (bus_req.addr == OFF_IRQ_MASK);
  assign rd_stat = bus_req.rd && (bus_req.addr == OFF_IRQ_STAT);

  // ==========================================================
  // event sources
  // stop mode gating
  assign det_run = st_q.undervolt_detect_enable && (!sys_in.stop_active || st_q.undervolt_stop_enable);
  assign det_set = det_run && st_q.det_s2;
  assign warn_set = st_q.warn_s2;
  assign deep_set = sys_in.deep_stop_wake;

  always_comb begin
    ev_new = '0;
    ev_new[B_EV_DETECT] = det_set && !st_q.undervolt_detect_flag;
    ev_new[B_EV_WARN] = warn_set && !st_q.supply_warning_flag;
    ev_new[B_EV_DEEP] = deep_set && !st_q.deep_stop_recovery_flag;
  end

  // ==========================================================
  // read views
  always_comb begin
    reg_one_view = '0;
    reg_one_view[B_DET_FLAG] = st_q.undervolt_detect_flag;
    reg_one_view[B_DET_IRQ_EN] = st_q.undervolt_irq_enable;
    reg_one_view[B_DET_RST_EN] = st_q.undervolt_reset_enable;
    reg_one_view[B_DET_STOP_EN] = st_q.undervolt_stop_enable;
    reg_one_view[B_DET_EN] = st_q.undervolt_detect_enable;
    reg_one_view[B_REF_BUF_EN] = st_q.reference_buffer_enable;
    // unused and ack positions read zero
    reg_two_view = '0;
    reg_two_view[B_WARN_FLAG] = st_q.supply_warning_flag;
    reg_two_view[B_DET_TRIP] = st_q.detect_trip_select;
    reg_two_view[B_WARN_TRIP] = st_q.warning_trip_select;
    reg_two_view[B_DEEP_FLAG] = st_q.deep_stop_recovery_flag;
    reg_two_view[B_STOP_DEPTH] = st_q.stop_depth_select;
  end

  // ==========================================================
  // next state
  always_comb begin
    st_d = st_q;
    st_d.det_s1 = analog_in.detect_cmp;
    st_d.det_s2 = st_q.det_s1;
    st_d.warn_s1 = analog_in.warn_cmp;
    st_d.warn_s2 = st_q.warn_s1;

    if (wr_one) begin
      st_d.undervolt_irq_enable = bus_req.wdata[B_DET_IRQ_EN];
      st_d.undervolt_reset_enable = bus_req.wdata[B_DET_RST_EN];
      st_d.undervolt_stop_enable = bus_req.wdata[B_DET_STOP_EN];
      st_d.undervolt_detect_enable = bus_req.wdata[B_DET_EN];
      st_d.reference_buffer_enable = bus_req.wdata[B_REF_BUF_EN];
    end

    if (wr_one && bus_req.wdata[B_DET_ACK]) begin
      st_d.undervolt_detect_flag = 1'b0;
    end
    if (det_set) begin
      st_d.undervolt_detect_flag = 1'b1;
    end

    if (wr_two) begin
      st_d.detect_trip_select = bus_req.wdata[B_DET_TRIP];
      st_d.warning_trip_select = bus_req.wdata[B_WARN_TRIP];
      if (!st_q.stop_depth_locked) begin
        st_d.stop_depth_select = bus_req.wdata[B_STOP_DEPTH];
        st_d.stop_depth_locked = 1'b1;
      end
    end

    if (wr_two && bus_req.wdata[B_WARN_ACK] && !st_q.warn_s2) begin
      st_d.supply_warning_flag = 1'b0;
    end
    if (warn_set) begin
      st_d.supply_warning_flag = 1'b1;
    end

    if (wr_two && bus_req.wdata[B_DEEP_ACK]) begin
      st_d.deep_stop_recovery_flag = 1'b0;
    end
    if (deep_set) begin
      st_d.deep_stop_recovery_flag = 1'b1;
    end

    if (wr_mask) begin
      st_d.ev_mask = bus_req.wdata[EV_W-1:0];
    end
    // status clear on read, new events win
    if (rd_stat) begin
      st_d.ev_stat = ev_new;
    end else begin
      st_d.ev_stat = st_q.ev_stat | ev_new;
    end

    // read data for one cycle only
    st_d.rdata = RD_IDLE;
    if (bus_req.rd) begin
      case (bus_req.addr)
        OFF_CTRL_ONE: begin
          st_d.rdata = reg_one_view;
        end
        OFF_CTRL_TWO: begin
          st_d.rdata = reg_two_view;
        end
        OFF_IRQ_STAT: begin
          st_d.rdata = {{(DATA_W-EV_W){1'b0}}, st_q.ev_stat};
        end
        OFF_IRQ_MASK: begin
          st_d.rdata = {{(DATA_W-EV_W){1'b0}}, st_q.ev_mask};
        end
        default: begin
          st_d.rdata = RD_IDLE;
        end
      endcase
    end

    st_d.irq = (st_q.undervolt_irq_enable && st_q.undervolt_detect_flag) || (|(st_q.ev_stat & st_q.ev_mask));
    st_d.reset_req = st_q.undervolt_reset_enable && st_q.undervolt_detect_enable && st_q.undervolt_detect_flag;
    st_d.detect_active = det_run;

    // reset values, trip selects kept unless power-on
    if (rst) begin
      st_d = '0;
      st_d.det_s1 = 1'b0;
      st_d.undervolt_irq_enable = RST_CTRL_ONE[B_DET_IRQ_EN];
      st_d.undervolt_reset_enable = RST_CTRL_ONE[B_DET_RST_EN];
      st_d.undervolt_stop_enable = RST_CTRL_ONE[B_DET_STOP_EN];
      st_d.undervolt_detect_enable = RST_CTRL_ONE[B_DET_EN];
      st_d.reference_buffer_enable = RST_CTRL_ONE[B_REF_BUF_EN];
      st_d.supply_warning_flag = RST_CTRL_TWO[B_WARN_FLAG];
      st_d.deep_stop_recovery_flag = RST_CTRL_TWO[B_DEEP_FLAG];
      st_d.stop_depth_select = RST_CTRL_TWO[B_STOP_DEPTH];
      st_d.ev_stat = RST_EV;
      st_d.ev_mask = RST_EV;
      st_d.rdata = RD_IDLE;
      // detect trip kept on non power-on reset
      // warning trip kept on non power-on reset
      if (sys_in.reset_is_por) begin
        st_d.detect_trip_select = RST_CTRL_TWO[B_DET_TRIP];
        st_d.warning_trip_select = RST_CTRL_TWO[B_WARN_TRIP];
      end else begin
        st_d.detect_trip_select = st_q.detect_trip_select;
        st_d.warning_trip_select = st_q.warning_trip_select;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    st_q <= st_d;
  end

  // ==========================================================
  // outputs
  assign rdata = st_q.rdata;
  assign irq = st_q.irq;
  assign reset_req = st_q.reset_req;
  assign reference_buffer_on = st_q.reference_buffer_enable;
  assign detect_active = st_q.detect_active;
  assign detect_trip_select = st_q.detect_trip_select;
  assign warning_trip_select = st_q.warning_trip_select;
  assign stop_depth_select = st_q.stop_depth_select;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  chk_det_flag_set: assert property (
    (st_q.undervolt_detect_enable && !sys_in.stop_active && st_q.det_s2) |=> st_q.undervolt_detect_flag)
    else $error("detect flag not set by detect event");

  chk_det_ack_clear: assert property (
    (wr_one && bus_req.wdata[B_DET_ACK] && !det_set) |=> !st_q.undervolt_detect_flag)
    else $error("detect ack did not clear flag");

  chk_det_irq_level: assert property (
    (st_q.undervolt_irq_enable && st_q.undervolt_detect_flag) |=> irq)
    else $error("detect interrupt missing");

  chk_det_reset_req: assert property (
    reset_req |-> $past(st_q.undervolt_detect_flag) && $past(st_q.undervolt_detect_enable))
    else $error("reset request without enabled flag");

  chk_stop_gating: assert property (
    (sys_in.stop_active && !st_q.undervolt_stop_enable && !st_q.undervolt_detect_flag && !wr_one)
      |=> !st_q.undervolt_detect_flag)
    else $error("detect flag set in stop while disabled");

  chk_det_disabled: assert property (
    (!st_q.undervolt_detect_enable && !st_q.undervolt_detect_flag) |=> !st_q.undervolt_detect_flag)
    else $error("detect flag set while detection off");

  chk_ref_buffer: assert property (
    (wr_one && !rst) |=> reference_buffer_on == $past(bus_req.wdata[B_REF_BUF_EN]))
    else $error("reference buffer not following write");

  chk_warn_sticky: assert property (
    (st_q.supply_warning_flag && !wr_two) |=> st_q.supply_warning_flag)
    else $error("warning flag dropped without ack");

  chk_warn_set: assert property (
    $rose(analog_in.warn_cmp) ##0 analog_in.warn_cmp [*3] |=> st_q.supply_warning_flag)
    else $error("warning flag not set by low supply");

  chk_warn_ack_hold: assert property (
    (wr_two && bus_req.wdata[B_WARN_ACK] && st_q.warn_s2) |=> st_q.supply_warning_flag)
    else $error("warning cleared while warning present");

  chk_stop_once: assert property (
    (st_q.stop_depth_locked && wr_two) |=> $stable(stop_depth_select))
    else $error("stop depth changed after first write");

  chk_deep_flag: assert property (
    sys_in.deep_stop_wake |=> st_q.deep_stop_recovery_flag)
    else $error("deep stop flag not set on wake");

  chk_rdata_idle: assert property (
    !bus_req.rd |=> rdata == RD_IDLE)
    else $error("read data outside read slot");

  chk_ack_bits_zero: assert property (
    (bus_req.rd && bus_req.addr == OFF_CTRL_TWO)
      |=> !rdata[B_WARN_ACK] && !rdata[B_DEEP_ACK] && !rdata[1] ##1 (rdata == RD_IDLE || $past(bus_req.rd)))
    else $error("ack or spare bits of second register read nonzero");

  chk_one_spare_zero: assert property (
    (bus_req.rd && bus_req.addr == OFF_CTRL_ONE)
      |=> !rdata[B_DET_ACK] && !rdata[0] ##1 (rdata == RD_IDLE || $past(bus_req.rd)))
    else $error("detect ack or spare bit read nonzero");

  chk_reset_req_set: assert property (
    (st_q.undervolt_reset_enable && st_q.undervolt_detect_enable && st_q.undervolt_detect_flag) |=> reset_req)
    else $error("reset request missing");

  chk_warn_ack_clear: assert property (
    (wr_two && bus_req.wdata[B_WARN_ACK] && !st_q.warn_s2) |=> !st_q.supply_warning_flag)
    else $error("warning ack did not clear flag");

  chk_deep_ack_clear: assert property (
    (wr_two && bus_req.wdata[B_DEEP_ACK] && !sys_in.deep_stop_wake) |=> !st_q.deep_stop_recovery_flag)
    else $error("deep stop ack did not clear flag");

  chk_warn_trip_write: assert property (
    wr_two |=> warning_trip_select == $past(bus_req.wdata[B_WARN_TRIP]))
    else $error("warning trip select not following write");

  chk_sync_delay: assert property (
    (!st_q.det_s1 && !st_q.det_s2 && !st_q.undervolt_detect_flag)
      |=> !st_q.undervolt_detect_flag ##1 !st_q.undervolt_detect_flag)
    else $error("detect flag set before comparator synchronised");

  chk_reset_values: assert property (disable iff (1'b0)
    rst |=> rdata == RD_IDLE && !irq && !reset_req && !reference_buffer_on && !detect_active
      && !stop_depth_select && !st_q.supply_warning_flag && !st_q.deep_stop_recovery_flag)
    else $error("register not cleared by reset");

  chk_trip_kept: assert property (disable iff (1'b0)
    (rst && !sys_in.reset_is_por) |=> $stable(detect_trip_select) && $stable(warning_trip_select))
    else $error("trip select changed by non power-on reset");

  chk_trip_por_clear: assert property (disable iff (1'b0)
    (rst && sys_in.reset_is_por) |=> !detect_trip_select && !warning_trip_select)
    else $error("trip select not cleared by power-on reset");

  cov_det_irq: cover property (det_set ##1 st_q.undervolt_irq_enable ##1 irq);
  cov_det_reset: cover property (reset_req);
  cov_warn_ack: cover property (wr_two && bus_req.wdata[B_WARN_ACK] && !st_q.warn_s2 && st_q.supply_warning_flag);
  cov_stop_once: cover property (st_q.stop_depth_locked && wr_two);
  cov_set_ack: cover property (wr_one && bus_req.wdata[B_DET_ACK] && det_set);

endmodule

`default_nettype wire

// ---- verification/tb_lvm_regs.sv ----
// self-checking testbench of the low-voltage monitor registers
`timescale 1ns/1ps
`default_nettype none

module tb_lvm_regs;
  import lvm_pkg::*;
  // ==========================================================
  // clock, reset and stimulus
  logic ref_clk;
  logic rst;
  lvm_bus_req_t req;
  lvm_analog_t ana;
  lvm_sys_t sys;
  logic [7:0] rdata;
  logic irq, reset_req, ref_on, det_act, det_trip, warn_trip, depth;
  int err_total;
  int comparisons;
  int cyc_cnt = 0;

  lvm_regs dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .bus_req(req),
    .rdata(rdata),
    .analog_in(ana),
    .sys_in(sys),
    .irq(irq),
    .reset_req(reset_req),
    .reference_buffer_on(ref_on),
    .detect_active(det_act),
    .detect_trip_select(det_trip),
    .warning_trip_select(warn_trip),
    .stop_depth_select(depth)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // shared tasks
  task automatic end_of_test();
    $display("checks %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string name);
    @(posedge ref_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    chk(name, exp, rdata);
    cyc(1);
    chk("rdata idle", 8'h00, rdata);
  endtask

  task automatic do_reset(input logic por, input int n);
    @(posedge ref_clk);
    rst <= 1'b1;
    sys.reset_is_por <= por;
    repeat (n) @(posedge ref_clk);
    rst <= 1'b0;
  endtask

  task automatic set_det(input logic x);
    @(posedge ref_clk);
    ana.detect_cmp <= x;
  endtask

  task automatic set_warn(input logic x);
    @(posedge ref_clk);
    ana.warn_cmp <= x;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset_values();
    rd(OFF_CTRL_ONE, RST_CTRL_ONE, "ctrl_one");
    rd(OFF_CTRL_TWO, RST_CTRL_TWO, "ctrl_two");
    rd(OFF_IRQ_MASK, 8'h00, "mask");
    wr(3'h5, 8'hff);
    rd(3'h5, 8'h00, "unmapped");
    rd(OFF_CTRL_ONE, 8'h00, "ctrl_one after unmapped");
  endtask

  task automatic t_detect();
    wr(OFF_CTRL_ONE, 8'h00);
    set_det(1'b1);
    cyc(5);
    rd(OFF_CTRL_ONE, 8'h00, "detect off");
    wr(OFF_CTRL_ONE, 8'h04);
    cyc(5);
    rd(OFF_CTRL_ONE, 8'h84, "detect flag");
    chk("irq disabled", 8'h00, {7'h0, irq});
    chk("reset_req off", 8'h00, {7'h0, reset_req});
    wr(OFF_CTRL_ONE, 8'h24);
    cyc(2);
    chk("irq enabled", 8'h01, {7'h0, irq});
    wr(OFF_CTRL_ONE, 8'h64);
    rd(OFF_CTRL_ONE, 8'ha4, "ack while present");
    set_det(1'b0);
    cyc(4);
    wr(OFF_CTRL_ONE, 8'h64);
    rd(OFF_CTRL_ONE, 8'h24, "ack clears");
    chk("irq cleared", 8'h00, {7'h0, irq});
    wr(OFF_CTRL_ONE, 8'h14);
    set_det(1'b1);
    cyc(5);
    chk("reset_req on", 8'h01, {7'h0, reset_req});
    wr(OFF_CTRL_ONE, 8'h10);
    cyc(2);
    chk("reset_req gated", 8'h00, {7'h0, reset_req});
    set_det(1'b0);
    cyc(4);
    wr(OFF_CTRL_ONE, 8'h40);
    rd(OFF_CTRL_ONE, 8'h00, "ctrl_one cleared");
  endtask

  task automatic t_stop_and_buffer();
    @(posedge ref_clk);
    sys.stop_active <= 1'b1;
    wr(OFF_CTRL_ONE, 8'h04);
    set_det(1'b1);
    cyc(5);
    chk("detect_active stop", 8'h00, {7'h0, det_act});
    rd(OFF_CTRL_ONE, 8'h04, "no flag in stop");
    wr(OFF_CTRL_ONE, 8'h0c);
    cyc(4);
    chk("detect_active stop en", 8'h01, {7'h0, det_act});
    set_det(1'b0);
    sys.stop_active <= 1'b0;
    cyc(4);
    wr(OFF_CTRL_ONE, 8'h42);
    cyc(1);
    chk("ref buffer", 8'h01, {7'h0, ref_on});
    rd(OFF_CTRL_ONE, 8'h02, "ctrl_one buffer");
    wr(OFF_CTRL_ONE, 8'h00);
  endtask

  task automatic t_warning();
    set_warn(1'b1);
    cyc(5);
    rd(OFF_CTRL_TWO, 8'h80, "warning flag");
    wr(OFF_CTRL_TWO, 8'h40);
    rd(OFF_CTRL_TWO, 8'h80, "warn ack refused");
    set_warn(1'b0);
    cyc(4);
    rd(OFF_CTRL_TWO, 8'h80, "warning latched");
    wr(OFF_CTRL_TWO, 8'h40);
    rd(OFF_CTRL_TWO, 8'h00, "warn ack clears");
  endtask

  task automatic t_deep_irq();
    rd(OFF_IRQ_STAT, 8'h03, "status before");
    wr(OFF_IRQ_MASK, 8'h04);
    rd(OFF_IRQ_MASK, 8'h04, "mask");
    @(posedge ref_clk);
    sys.deep_stop_wake <= 1'b1;
    @(posedge ref_clk);
    sys.deep_stop_wake <= 1'b0;
    cyc(3);
    chk("irq deep", 8'h01, {7'h0, irq});
    rd(OFF_CTRL_TWO, 8'h08, "deep flag");
    rd(OFF_IRQ_STAT, 8'h04, "status deep");
    cyc(1);
    chk("irq after read", 8'h00, {7'h0, irq});
    wr(OFF_CTRL_TWO, 8'h04);
    rd(OFF_CTRL_TWO, 8'h00, "deep ack");
    wr(OFF_IRQ_MASK, 8'h00);
  endtask

  task automatic t_trip_depth();
    do_reset(1'b1, 2);
    wr(OFF_CTRL_TWO, 8'h31);
    cyc(1);
    chk("trip and depth", 8'h07, {5'h0, det_trip, warn_trip, depth});
    rd(OFF_CTRL_TWO, 8'h31, "ctrl_two written");
    wr(OFF_CTRL_TWO, 8'h30);
    rd(OFF_CTRL_TWO, 8'h31, "depth write once");
    do_reset(1'b0, 2);
    cyc(1);
    rd(OFF_CTRL_TWO, 8'h30, "trips kept");
    chk("depth reset", 8'h00, {7'h0, depth});
    set_warn(1'b1);
    do_reset(1'b1, 2);
    cyc(4);
    rd(OFF_CTRL_TWO, 8'h80, "por clears, warn after reset");
    set_warn(1'b0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    err_total = 0;
    comparisons = 0;
    rst = 1'b1;
    req = '0;
    ana = '0;
    sys = '0;
    sys.reset_is_por = 1'b1;
    do_reset(1'b1, 12);
    t_reset_values();
    t_detect();
    t_stop_and_buffer();
    t_warning();
    t_deep_irq();
    t_trip_depth();
    end_of_test();
  end
endmodule

`default_nettype wire
